// ### tpwmc_top.sv
// Timer PWM control registers with AXI4-Lite slave and channel output logic
// Functional notes
// (RL1) Force strobe ignored while channel in PWM
// (RL2) Force applies compare action, no flag
// (RL3) Same-write mode is used for force
// (RL4) Force strobe bits always read zero
// (RL5) PWM enable selects PWM per channel
// (RL6) Inversion bit inverts both dead-time outputs
// (RL7) Prescaler clear self-clears, reads zero, keeps count
// (RL8) Dead-time prescaler divides by 1,2,4,8
// (RL9) Clock select zero stops, else 2^(n-1)
// (RL10) Upper bits shadow channel A/B modes
// (RL11) Nonzero D mode takes pin; complement only 01
// (RL12) Software sets port direction for D pin
// (RL13) Non-PWM D: toggle, clear, set on match
// (RL14) Fast PWM D: match/zero set-clear behaviour
// (RL15) Phase-correct D: up/down match behaviour
// (RL16) Wave mode bits select PWM flavour
// (RL17) Clock source choice comes from outside
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tpwmc_top
   import tpwmc_pkg::*;
(
   // Clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // AXI4-Lite write address and data
   input  wire logic [9:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // AXI4-Lite read
   input  wire logic [9:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // Counter core and mode inputs, same clock
   input  wire logic                    wave_mode_bit0,
   input  wire logic                    wave_mode_bit1,
   input  wire logic                    use_fast_timebase,
   input  wire logic                    fast_timebase_tick,
   input  wire logic                    match_d,
   input  wire logic                    count_zero,
   input  wire logic                    count_down,
   input  wire logic                    deadtime_true_in,
   input  wire logic                    deadtime_comp_in,
   // Control outputs
   output logic                         timer_tick,
   output logic                         deadtime_tick,
   output logic                         prescaler_cleared,
   output logic [1:0]                   out_mode_a,
   output logic [1:0]                   out_mode_b,
   output logic                         pwm_enable_a,
   output logic                         pwm_enable_b,
   output logic                         force_match_a,
   output logic                         force_match_b,
   output logic                         deadtime_true_out,
   output logic                         deadtime_comp_out,
   output logic                         waveform_d,
   output logic                         compare_pin_d_take,
   output logic                         compare_pin_d_comp_take
);
   import tpwmc_pkg::*;

   // ****************************************
   // Register bus
   // ****************************************
   logic [7:0]  chd_q;
   logic [7:0]  clk_q;
   logic [7:0]  ab_q;
   logic        psc_clr_q;
   logic        aw_q, w_q;
   logic [9:0]  awaddr_q;
   logic [7:0]  wdata_q;
   logic        wlane_q;
   logic        bvalid_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic        wr_go;
   logic        wr_hit;
   logic        wr_chd, wr_clk, wr_ab;
   logic [7:0]  rd_val;
   logic        rd_hit;

   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready  = !w_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign wr_go  = aw_q && w_q && !bvalid_q;
   assign wr_hit = (awaddr_q == TPWMC_ADDR_CHD_MODE) || (awaddr_q == TPWMC_ADDR_CLK_DT)
                   || (awaddr_q == TPWMC_ADDR_CH_AB_CTRL);
   assign wr_chd = wr_go && wlane_q && (awaddr_q == TPWMC_ADDR_CHD_MODE);
   assign wr_clk = wr_go && wlane_q && (awaddr_q == TPWMC_ADDR_CLK_DT);
   assign wr_ab  = wr_go && wlane_q && (awaddr_q == TPWMC_ADDR_CH_AB_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 1'b0;
         awaddr_q <= 10'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_q     <= 1'b1;
         awaddr_q <= {s_axi_awaddr[9:2], 2'b00};
      end else if (wr_go) begin
         aw_q     <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_q     <= 1'b0;
         wdata_q <= 8'h00;
         wlane_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_q     <= 1'b1;
         wdata_q <= s_axi_wdata[7:0];
         wlane_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_q     <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= TPWMC_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? TPWMC_RESP_OKAY : TPWMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Strobe bits are never stored, so reads give zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chd_q <= TPWMC_RST_CHD_MODE;
      end else if (wr_chd) begin
         chd_q <= wdata_q & ~(8'h01 << TPWMC_B_FORCE_D); // RL4
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_q <= TPWMC_RST_CLK_DT;
      end else if (wr_clk) begin
         clk_q <= wdata_q & ~(8'h01 << TPWMC_B_PSC_CLR); // RL7
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ab_q <= TPWMC_RST_CH_AB_CTRL;
      end else if (wr_ab) begin
         ab_q <= wdata_q & ~((8'h01 << TPWMC_B_FORCE_A) | (8'h01 << TPWMC_B_FORCE_B)); // RL4
      end
   end

   // Mode registers also shadowed in the upper channel D bits
   assign out_mode_a   = chd_q[TPWMC_B_SHADOW_A +: 2]; // RL10
   assign out_mode_b   = chd_q[TPWMC_B_SHADOW_B +: 2]; // RL10
   assign pwm_enable_a = ab_q[TPWMC_B_PWM_A]; // RL5
   assign pwm_enable_b = ab_q[TPWMC_B_PWM_B]; // RL5

   // Forces for A and B, gated by non-PWM setting in the same write
   assign force_match_a = wr_ab && wdata_q[TPWMC_B_FORCE_A] && !wdata_q[TPWMC_B_PWM_A]; // RL1
   assign force_match_b = wr_ab && wdata_q[TPWMC_B_FORCE_B] && !wdata_q[TPWMC_B_PWM_B]; // RL1

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= TPWMC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h00_0000, rd_val};
         rresp_q  <= rd_hit ? TPWMC_RESP_OKAY : TPWMC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_comb begin
      rd_val = 8'h00;
      rd_hit = 1'b1;
      case ({s_axi_araddr[9:2], 2'b00})
         TPWMC_ADDR_CHD_MODE:   rd_val = chd_q;
         TPWMC_ADDR_CLK_DT:     rd_val = clk_q;
         TPWMC_ADDR_CH_AB_CTRL: rd_val = ab_q;
         TPWMC_ADDR_STATUS:     rd_val = {6'h00, waveform_d, psc_clr_q};
         default:               rd_hit = 1'b0;
      endcase
   end

   // ****************************************
   // Prescalers
   // ****************************************
   logic [TPWMC_PSC_W-1:0] psc_q;
   logic [2:0]             dt_q;
   logic                   src_tick;
   logic [3:0]             sel;
   logic [1:0]             dt_sel;
   logic [TPWMC_PSC_W-1:0] psc_mask;
   logic [2:0]             dt_mask;

   assign src_tick = use_fast_timebase ? fast_timebase_tick : 1'b1; // RL17
   assign sel      = clk_q[TPWMC_B_CLK_SEL +: 4];
   assign dt_sel   = clk_q[TPWMC_B_DT_DIV +: 2];
   assign psc_mask = TPWMC_PSC_W'((15'h0001 << (sel - 4'h1)) - 15'h0001);
   assign dt_mask  = 3'((4'h1 << dt_sel) - 4'h1);

   // Prescaler clear restarts division, counter untouched
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psc_clr_q <= 1'b0;
      end else begin
         psc_clr_q <= wr_clk && wdata_q[TPWMC_B_PSC_CLR]; // RL7
      end
   end
   assign prescaler_cleared = psc_clr_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || psc_clr_q) begin
         psc_q <= '0; // RL7
      end else if (src_tick && sel != 4'h0) begin
         psc_q <= psc_q + TPWMC_PSC_W'(1);
      end
   end

   // Tick when all low bits below the selected divider are set
   assign timer_tick = src_tick && (sel != 4'h0) && ((psc_q & psc_mask) == psc_mask); // RL9

   always_ff @(posedge aclk) begin
      if (!aresetn || psc_clr_q) begin
         dt_q <= 3'h0;
      end else if (timer_tick) begin
         dt_q <= dt_q + 3'h1;
      end
   end
   assign deadtime_tick = timer_tick && ((dt_q & dt_mask) == dt_mask); // RL8

   // ****************************************
   // Dead-time inversion and channel D
   // ****************************************
   assign deadtime_true_out = deadtime_true_in ^ clk_q[TPWMC_B_INVERT]; // RL6
   assign deadtime_comp_out = deadtime_comp_in ^ clk_q[TPWMC_B_INVERT]; // RL6

   tpwmc_out_mode_t  mode_d;
   tpwmc_wave_mode_t wmode;
   logic             pwm_d;
   logic             force_d;
   logic             wave_d_q;
   logic [1:0]       new_mode_d;

   assign pwm_d      = chd_q[TPWMC_B_PWM_D]; // RL5
   assign mode_d     = tpwmc_out_mode_t'(chd_q[TPWMC_B_MODE_D +: 2]);
   assign wmode      = tpwmc_wave_mode_t'({wave_mode_bit1, wave_mode_bit0}); // RL16
   assign new_mode_d = wdata_q[TPWMC_B_MODE_D +: 2];
   assign force_d    = wr_chd && wdata_q[TPWMC_B_FORCE_D] && !wdata_q[TPWMC_B_PWM_D]; // RL1

   // Force takes priority and uses the mode of the same write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave_d_q <= 1'b0;
      end else if (force_d) begin
         case (new_mode_d) // RL2 RL3
            2'b01:   wave_d_q <= !wave_d_q;
            2'b10:   wave_d_q <= 1'b0;
            2'b11:   wave_d_q <= 1'b1;
            default: wave_d_q <= wave_d_q;
         endcase
      end else if (!pwm_d) begin
         if (match_d) begin
            case (mode_d) // RL13
               TPWMC_OM_TGL: wave_d_q <= !wave_d_q;
               TPWMC_OM_CLR: wave_d_q <= 1'b0;
               TPWMC_OM_SET: wave_d_q <= 1'b1;
               default:      wave_d_q <= wave_d_q;
            endcase
         end
      end else if (mode_d != TPWMC_OM_PORT) begin
         case (wmode)
            TPWMC_WM_FAST, TPWMC_WM_SS6: begin
               if (match_d) begin
                  wave_d_q <= (mode_d == TPWMC_OM_SET); // RL14
               end else if (count_zero) begin
                  wave_d_q <= (mode_d != TPWMC_OM_SET); // RL14
               end
            end
            default: begin
               if (match_d) begin
                  wave_d_q <= (mode_d == TPWMC_OM_SET) ^ count_down; // RL15
               end
            end
         endcase
      end
   end
   assign waveform_d = wave_d_q;

   // Pin ownership; port direction stays with software
   assign compare_pin_d_take      = (mode_d != TPWMC_OM_PORT); // RL11 RL12
   assign compare_pin_d_comp_take = pwm_d && (mode_d == TPWMC_OM_TGL); // RL11
endmodule
`default_nettype wire

// ### tpwmc_pkg.sv
// Package: register map, field positions and codes for the timer PWM control block
`default_nettype none
package tpwmc_pkg;
   // Register indices as printed, byte address is four times the index
   localparam logic [7:0]  TPWMC_IDX_CHD_MODE   = 8'h27;
   localparam logic [7:0]  TPWMC_IDX_CLK_DT     = 8'h2f;
   localparam logic [7:0]  TPWMC_IDX_CH_AB_CTRL = 8'h30;
   localparam logic [9:0]  TPWMC_ADDR_CHD_MODE   = {TPWMC_IDX_CHD_MODE, 2'b00};
   localparam logic [9:0]  TPWMC_ADDR_CLK_DT     = {TPWMC_IDX_CLK_DT, 2'b00};
   localparam logic [9:0]  TPWMC_ADDR_CH_AB_CTRL = {TPWMC_IDX_CH_AB_CTRL, 2'b00};
   localparam logic [9:0]  TPWMC_ADDR_STATUS     = 10'h0c4;
   localparam logic [7:0]  TPWMC_RST_CHD_MODE   = 8'h00;
   localparam logic [7:0]  TPWMC_RST_CLK_DT     = 8'h00;
   localparam logic [7:0]  TPWMC_RST_CH_AB_CTRL = 8'h00;
   // Channel D mode register fields
   localparam int TPWMC_B_SHADOW_A = 6;
   localparam int TPWMC_B_SHADOW_B = 4;
   localparam int TPWMC_B_MODE_D   = 2;
   localparam int TPWMC_B_FORCE_D  = 1;
   localparam int TPWMC_B_PWM_D    = 0;
   // Clock and dead-time register fields
   localparam int TPWMC_B_INVERT   = 7;
   localparam int TPWMC_B_PSC_CLR  = 6;
   localparam int TPWMC_B_DT_DIV   = 4;
   localparam int TPWMC_B_CLK_SEL  = 0;
   // Channel A/B control register fields
   localparam int TPWMC_B_MODE_A   = 6;
   localparam int TPWMC_B_MODE_B   = 4;
   localparam int TPWMC_B_FORCE_A  = 3;
   localparam int TPWMC_B_FORCE_B  = 2;
   localparam int TPWMC_B_PWM_A    = 1;
   localparam int TPWMC_B_PWM_B    = 0;
   localparam int TPWMC_PSC_W      = 14;
   localparam logic [1:0] TPWMC_RESP_OKAY   = 2'b00;
   localparam logic [1:0] TPWMC_RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      TPWMC_WM_FAST = 2'b00,
      TPWMC_WM_PFC  = 2'b01,
      TPWMC_WM_SS6  = 2'b10,
      TPWMC_WM_DS6  = 2'b11
   } tpwmc_wave_mode_t;
   typedef enum logic [1:0] {
      TPWMC_OM_PORT = 2'b00,
      TPWMC_OM_TGL  = 2'b01,
      TPWMC_OM_CLR  = 2'b10,
      TPWMC_OM_SET  = 2'b11
   } tpwmc_out_mode_t;
endpackage
`default_nettype wire

// ### tpwmc_sva.sv
// Checker: bus and output relations of the timer PWM control block
`timescale 1ns/10ps
`default_nettype none
module tpwmc_sva (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Control outputs and dead-time inputs
   input wire logic        force_match_a,
   input wire logic        force_match_b,
   input wire logic        pwm_enable_a,
   input wire logic        pwm_enable_b,
   input wire logic        deadtime_true_in,
   input wire logic        deadtime_comp_in,
   input wire logic        deadtime_true_out,
   input wire logic        deadtime_comp_out,
   input wire logic        prescaler_cleared,
   input wire logic        compare_pin_d_take,
   input wire logic        compare_pin_d_comp_take
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write response late");
   rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data above byte lane");
   force_a_gate_a: assert property (force_match_a |=> !pwm_enable_a)
      else $error("force A fired in PWM");
   force_b_gate_a: assert property (force_match_b |=> !pwm_enable_b)
      else $error("force B fired in PWM");
   invert_pair_a: assert property ((deadtime_true_out ^ deadtime_true_in) ==
      (deadtime_comp_out ^ deadtime_comp_in)) else $error("outputs inverted unequally");
   psc_pulse_a: assert property (prescaler_cleared |=> !prescaler_cleared)
      else $error("prescaler clear not a pulse");
   comp_take_a: assert property (compare_pin_d_comp_take |-> compare_pin_d_take)
      else $error("complement without true pin");
endmodule
bind tpwmc_top tpwmc_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .force_match_a, .force_match_b, .pwm_enable_a, .pwm_enable_b,
   .deadtime_true_in, .deadtime_comp_in, .deadtime_true_out, .deadtime_comp_out,
   .prescaler_cleared, .compare_pin_d_take, .compare_pin_d_comp_take);
`default_nettype wire

// ### tb_top.sv
// Testbench: register access, forced compares, output modes and prescalers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import tpwmc_pkg::*;
   localparam logic [9:0] A_D = TPWMC_ADDR_CHD_MODE;
   localparam logic [9:0] A_C = TPWMC_ADDR_CLK_DT;
   localparam logic [9:0] A_AB = TPWMC_ADDR_CH_AB_CTRL;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [9:0]  s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp, out_mode_a, out_mode_b;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        wave_mode_bit0 = 1'b0, wave_mode_bit1 = 1'b0, use_fast_timebase = 1'b0;
   logic        fast_timebase_tick = 1'b0, match_d = 1'b0, count_zero = 1'b0;
   logic        count_down = 1'b0, deadtime_true_in = 1'b0, deadtime_comp_in = 1'b0;
   logic        timer_tick, deadtime_tick, prescaler_cleared, pwm_enable_a, pwm_enable_b;
   logic        force_match_a, force_match_b, deadtime_true_out, deadtime_comp_out;
   logic        waveform_d, compare_pin_d_take, compare_pin_d_comp_take;
   int          failures = 0, compares = 0, cycles = 0;
   int          tt_n = 0, dt_n = 0, fa_n = 0, fb_n = 0, pc_n = 0;

   tpwmc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wave_mode_bit0, .wave_mode_bit1,
      .use_fast_timebase, .fast_timebase_tick, .match_d, .count_zero, .count_down,
      .deadtime_true_in, .deadtime_comp_in, .timer_tick, .deadtime_tick, .prescaler_cleared,
      .out_mode_a, .out_mode_b, .pwm_enable_a, .pwm_enable_b, .force_match_a, .force_match_b,
      .deadtime_true_out, .deadtime_comp_out, .waveform_d, .compare_pin_d_take,
      .compare_pin_d_comp_take);

   always #2.5 aclk = ~aclk;
   always @(posedge aclk) fast_timebase_tick <= ~fast_timebase_tick;
   // Pulse counters and hang limit
   always @(negedge aclk) begin
      cycles++;
      tt_n += int'(timer_tick === 1'b1);
      dt_n += int'(deadtime_tick === 1'b1);
      fa_n += int'(force_match_a === 1'b1);
      fb_n += int'(force_match_b === 1'b1);
      pc_n += int'(prescaler_cleared === 1'b1);
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic stop_test;
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(negedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) aw_d = 1'b1;
         if (s_axi_wvalid && s_axi_wready === 1'b1) w_d = 1'b1;
         @(posedge aclk);
         if (aw_d) s_axi_awvalid <= 1'b0;
         if (w_d) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rchk(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
      logic ar_d;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_d = (s_axi_arready === 1'b1);
         @(posedge aclk);
      end while (!ar_d);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk(rd, e);
      chk(resp, r);
   endtask
   // Kind 0 match up, 1 match down, 2 counter zero
   task automatic mt(input int k, input logic e);
      @(posedge aclk);
      count_down <= (k == 1);
      match_d <= (k != 2);
      count_zero <= (k == 2);
      @(posedge aclk);
      match_d <= 1'b0;
      count_zero <= 1'b0;
      @(negedge aclk);
      chk(waveform_d, e);
   endtask
   task automatic win(input int n_tt, input int n_dt);
      repeat (64) @(posedge aclk);
      tt_n = 0;
      dt_n = 0;
      repeat (64) @(posedge aclk);
      chk(tt_n, n_tt);
      if (n_dt >= 0) chk(dt_n, n_dt);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      rchk(A_D, 32'h0, TPWMC_RESP_OKAY);
      rchk(A_C, 32'h0, TPWMC_RESP_OKAY);
      rchk(A_AB, 32'h0, TPWMC_RESP_OKAY);
      rchk(10'h000, 32'h0, TPWMC_RESP_SLVERR);
      wr(10'h000, 8'hff);
      chk(resp, TPWMC_RESP_SLVERR);
   endtask
   task automatic t_force_d;
      wr(A_D, 8'h0e);
      chk(waveform_d, 1'b1);
      chk({compare_pin_d_take, compare_pin_d_comp_take}, 2'b10);
      rchk(A_D, 32'h0c, TPWMC_RESP_OKAY);
      rchk(TPWMC_ADDR_STATUS, 32'h02, TPWMC_RESP_OKAY);
      wr(A_D, 8'h0b);
      chk(waveform_d, 1'b1);
      wr(A_D, 8'h04);
      mt(0, 1'b0);
      mt(1, 1'b1);
      wr(A_D, 8'h08);
      mt(0, 1'b0);
      wr(A_D, 8'h0c);
      mt(0, 1'b1);
      wr(A_D, 8'h06);
      chk(waveform_d, 1'b0);
      wr(A_D, 8'h00);
      chk(compare_pin_d_take, 1'b0);
   endtask
   task automatic t_pwm;
      wr(A_D, 8'h05);
      chk(compare_pin_d_comp_take, 1'b1);
      mt(2, 1'b1);
      mt(0, 1'b0);
      wr(A_D, 8'h0d);
      chk(compare_pin_d_comp_take, 1'b0);
      mt(0, 1'b1);
      mt(2, 1'b0);
      @(posedge aclk);
      wave_mode_bit0 <= 1'b1;
      mt(0, 1'b1);
      mt(1, 1'b0);
      wr(A_D, 8'h09);
      mt(1, 1'b1);
      mt(0, 1'b0);
      @(posedge aclk);
      wave_mode_bit0 <= 1'b0;
      wave_mode_bit1 <= 1'b1;
      mt(2, 1'b1);
      @(posedge aclk);
      wave_mode_bit0 <= 1'b1;
      mt(0, 1'b0);
      mt(1, 1'b1);
   endtask
   task automatic t_ab;
      wr(A_AB, 8'h0a);
      chk(fa_n, 0);
      chk(pwm_enable_a, 1'b1);
      wr(A_AB, 8'h04);
      chk(fb_n, 1);
      chk(pwm_enable_a, 1'b0);
      wr(A_AB, 8'h09);
      chk(fa_n, 1);
      chk(pwm_enable_b, 1'b1);
      rchk(A_AB, 32'h01, TPWMC_RESP_OKAY);
      wr(A_D, 8'hd0);
      chk(resp, TPWMC_RESP_OKAY);
      chk({out_mode_a, out_mode_b}, 4'hd);
      rchk(A_D, 32'hd0, TPWMC_RESP_OKAY);
   endtask
   task automatic t_clk;
      deadtime_true_in <= 1'b1;
      wr(A_C, 8'h81);
      chk({deadtime_true_out, deadtime_comp_out}, 2'b01);
      wr(A_C, 8'h41);
      chk(pc_n, 1);
      chk(deadtime_true_out, 1'b1);
      rchk(A_C, 32'h01, TPWMC_RESP_OKAY);
      for (int n = 0; n < 7; n++) begin
         wr(A_C, 8'(n));
         win((n == 0) ? 0 : (64 >> (n - 1)), -1);
      end
      for (int c = 0; c < 4; c++) begin
         wr(A_C, {2'b00, c[1:0], 4'h1});
         win(64, 64 >> c);
      end
      use_fast_timebase <= 1'b1;
      win(32, -1);
   endtask

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_force_d();
      t_pwm();
      t_ab();
      t_clk();
      stop_test();
   end
endmodule
`default_nettype wire
